// [tb_top.sv]
// Self-checking bench for the timer control block.
// Assumes design files and pin model compiled first.
`timescale 1ns/1ns
module tb_top;
    reg        sys_clk   = 1'b0;  // Timer clock, 40 ns
    reg        rst_n     = 1'b0;  // Reset, active low
    reg  [3:0] reg_addr  = 4'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr    = 1'b0;
    reg        reg_rd    = 1'b0;
    reg        cpu_mask  = 1'b0;  // Core mask, 1 masks
    reg        halt_mode = 1'b0;
    reg        req_one   = 1'b0;  // Wanted capture levels
    reg        req_two   = 1'b0;
    wire [7:0] reg_rdata;
    wire       cap_one, cap_two, out_one, oe_one, out_two, oe_two, irq, wake, ld_one, ld_two;
    integer    n_fail    = 0;
    integer    cmp_count = 0;
    reg  [7:0] rv, hv, lv;        // Read data and held counter bytes
    always #20 sys_clk = ~sys_clk;
    tmctl_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_mask(cpu_mask), .halt_mode(halt_mode), .capture_in_pin_one(cap_one),
        .capture_in_pin_two(cap_two), .compare_out_pin_one(out_one),
        .compare_out_pin_one_oe(oe_one), .compare_out_pin_two(out_two),
        .compare_out_pin_two_oe(oe_two), .timer_irq(irq), .wake_from_wait(wake));
    tmctl_pin_model PEER (.sys_clk(sys_clk), .req_one(req_one), .req_two(req_two),
        .pin_one(out_one), .oe_one(oe_one), .pin_two(out_two), .oe_two(oe_two),
        .cap_one(cap_one), .cap_two(cap_two), .load_one(ld_one), .load_two(ld_two));
    // ****************************************
    // Bus, wait and compare tasks
    // ****************************************
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    // Data stands one cycle after the strobe
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t byte %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk1(input got, input exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t bit %b expected %b", $time, got, exp);
            end
        end
    endtask
    // Capture pin one level, then settle
    task pin1(input lvl);
        begin
            @(posedge sys_clk);
            req_one <= lvl;
            cyc(6);
        end
    endtask
    task finish_test;
        begin
            $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Watchdog, several run lengths
    initial begin
        #(40 * 4000);
        n_fail = n_fail + 1;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(4'h2, rv); chk8(rv, 8'h00);
        rd(4'h1, rv); chk8(rv, 8'h00);
        rd(4'h6, rv); chk8(rv, 8'h80);
        rd(4'h0, rv); chk8(rv, 8'h00);
        // Forcing, then pins released
        wr(4'h1, 8'hC0);
        wr(4'h2, 8'h1D); cyc(2);
        chk1(ld_one, 1'b1);
        chk1(ld_two, 1'b1);
        wr(4'h2, 8'h18); cyc(2);
        chk1(ld_one | ld_two, 1'b0);
        wr(4'h1, 8'h00); cyc(2);
        chk1(ld_one & ld_two, 1'b1);
        // High byte alone must hold compare one off
        wr(4'h2, 8'h01);
        wr(4'h1, 8'h80);
        wr(4'h6, 8'h00);
        wr(4'hD, 8'h00); cyc(30);
        rd(4'h3, rv); chk1(rv[6], 1'b0);
        chk1(ld_one, 1'b0);
        wr(4'h7, 8'h40); cyc(60);
        rd(4'h3, rv); chk1(rv[6], 1'b1);
        chk1(ld_one, 1'b1);
        // Overflow via enable and mask
        wr(4'h1, 8'h02);
        wr(4'h2, 8'h00); cyc(1); chk1(irq, 1'b0);
        wr(4'h2, 8'h20); cyc(1); chk1(irq, 1'b1);
        chk1(wake, 1'b1);
        @(posedge sys_clk); cpu_mask <= 1'b1; cyc(1); chk1(irq, 1'b0);
        @(posedge sys_clk); cpu_mask <= 1'b0; halt_mode <= 1'b1; cyc(1);
        chk1(wake, 1'b0);
        // Halt freezes count; edge arms
        @(posedge sys_clk); req_two <= 1'b1; cyc(6);
        rd(4'h3, rv); chk1(rv[4], 1'b0);
        rd(4'hC, hv);
        rd(4'hD, lv); cyc(5);
        rd(4'hD, rv); chk8(rv, lv);
        @(posedge sys_clk); halt_mode <= 1'b0; cyc(3);
        rd(4'h8, rv); chk8(rv, hv);
        rd(4'h9, rv); chk8(rv, lv);
        wr(4'h2, 8'h00);
        rd(4'h3, rv); chk1(rv[4], 1'b1);
        chk1(irq, 1'b0);
        wr(4'h2, 8'h80); cyc(1); chk1(irq, 1'b1);
        rd(4'h3, rv);
        rd(4'h9, rv); cyc(1); chk1(irq, 1'b0);
        // Edge select one, both polarities
        wr(4'h2, 8'h82);
        pin1(1'b1); chk1(irq, 1'b1);
        rd(4'h3, rv);
        rd(4'h5, rv); cyc(1); chk1(irq, 1'b0);
        wr(4'h2, 8'h80);
        pin1(1'b0); chk1(irq, 1'b1);
        rd(4'h3, rv);
        rd(4'h5, rv);
        pin1(1'b1); chk1(irq, 1'b0);
        // Pulse-width beats one-pulse
        rd(4'h3, rv);
        rd(4'h7, rv);
        wr(4'hA, 8'h00);
        wr(4'hB, 8'h20);
        wr(4'h1, 8'hB0);
        wr(4'hD, 8'h00); cyc(300);
        rd(4'h3, rv); chk1(rv[7], 1'b1);
        chk1(rv[6] | rv[3], 1'b0);
        chk1(irq, 1'b1);
        rd(4'hC, rv); chk1(rv == 8'h00 || rv == 8'hFF, 1'b1);
        // One-pulse alone
        wr(4'h2, 8'h86); wr(4'h1, 8'hA0); pin1(1'b0);
        pin1(1'b1); chk1(ld_one, 1'b1);
        rd(4'h5, rv); chk8(rv, 8'hFD);
        cyc(70); chk1(ld_one, 1'b0);
        finish_test;
    end
endmodule

// [tmctl_consts.vh]
// Constants for the 16-bit timer control block.
// Assumes inclusion by bare name from the timer design files.
`ifndef TMCTL_CONSTS_VH
`define TMCTL_CONSTS_VH

// ****************************************************
// Register offsets (byte registers on the plain port)
// ****************************************************
`define TMCTL_ADR_CTL2      4'h1
`define TMCTL_ADR_CTL1      4'h2
`define TMCTL_ADR_STAT      4'h3
`define TMCTL_ADR_CAP1_HI   4'h4
`define TMCTL_ADR_CAP1_LO   4'h5
`define TMCTL_ADR_CMP1_HI   4'h6
`define TMCTL_ADR_CMP1_LO   4'h7
`define TMCTL_ADR_CAP2_HI   4'h8
`define TMCTL_ADR_CAP2_LO   4'h9
`define TMCTL_ADR_CMP2_HI   4'hA
`define TMCTL_ADR_CMP2_LO   4'hB
`define TMCTL_ADR_CNT_HI    4'hC
`define TMCTL_ADR_CNT_LO    4'hD

// ****************************************************
// Control one fields
// ****************************************************
`define TMCTL_C1_CAP_IE     7
`define TMCTL_C1_CMP_IE     6
`define TMCTL_C1_OVF_IE     5
`define TMCTL_C1_FORCE2     4
`define TMCTL_C1_FORCE1     3
`define TMCTL_C1_LVL2       2
`define TMCTL_C1_EDGE1      1
`define TMCTL_C1_LVL1       0

// ****************************************************
// Control two fields
// ****************************************************
`define TMCTL_C2_PIN1_EN    7
`define TMCTL_C2_PIN2_EN    6
`define TMCTL_C2_ONE_PULSE  5
`define TMCTL_C2_PWM        4
`define TMCTL_C2_EDGE2      1

// ****************************************************
// Status fields
// ****************************************************
`define TMCTL_ST_CAP1       7
`define TMCTL_ST_CMP1       6
`define TMCTL_ST_OVF        5
`define TMCTL_ST_CAP2       4
`define TMCTL_ST_CMP2       3

// ****************************************************
// Reset values and fixed loads
// ****************************************************
`define TMCTL_CTL1_RST      8'h00
`define TMCTL_CTL2_RST      8'h00
`define TMCTL_CMP_RST       16'h8000
`define TMCTL_CNT_RST       16'hFFFC
`define TMCTL_CNT_RELOAD    16'hFFFC
`define TMCTL_CAP_OPM_VAL   16'hFFFD

`endif

// [tmctl_edge.v]
// Synchronises one capture pin and detects its selected edge.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ns

module tmctl_edge (
    sys_clk,
    rst_n,
    pin_in,
    rise_sel,
    edge_hit
);
    input  wire sys_clk;   // Timer clock
    input  wire rst_n;     // Async reset, active low
    input  wire pin_in;    // Raw capture pin
    input  wire rise_sel;  // 1 rising, 0 falling
    output wire edge_hit;  // One-cycle pulse on selected edge

    reg sync1_ff;  // First stage, read only by second
    reg sync2_ff;  // Second stage
    reg prev_ff;   // Delayed copy for edge detection

    // ****************************************************
    // Two-stage synchroniser and history
    // ****************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Edge polarity chosen by software
    assign edge_hit = rise_sel ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);
endmodule

// [tmctl_pin_model.sv]
// Far side of the timer: capture sources and compare loads with pull-ups.
// Assumes the bench requests capture levels.
`timescale 1ns/1ns
module tmctl_pin_model (
    input  wire sys_clk,
    input  wire req_one,
    input  wire req_two,
    input  wire pin_one,
    input  wire oe_one,
    input  wire pin_two,
    input  wire oe_two,
    output reg  cap_one = 1'b0,
    output reg  cap_two = 1'b0,
    output wire load_one,
    output wire load_two
);
    // Sources settle 3 ns past the edge
    always @(posedge sys_clk) begin
        cap_one <= #3 req_one;
        cap_two <= #3 req_two;
    end
    // Released lines go to the pull-up
    assign load_one = oe_one ? pin_one : 1'b1;
    assign load_two = oe_two ? pin_two : 1'b1;
endmodule

// [tmctl_timer.v]
// 16-bit free-running timer control: modes, low power, events and interrupt.
// Assumes a byte register port and core halt and mask.
//
// Summary of operation
// - Compare high write suspends compare until low
// - No compare flags set in pulse-width mode
// - Pulse-width: second compare sets capture one flag
// - Pulse-width: pin one disconnected, pin two captures
// - Pulse-width wins over one-pulse
// - Wait mode: timer runs, interrupts wake
// - Halt stops counter; resumes or restarts
// - Edge in halt arms capture at exit
// - Enabled, unmasked events end wait, none halt
// - One vector, enable and mask gate
// - Capture enable gates both capture flags
// - Compare enable gates both compare flags
// - Overflow enable gates overflow flag
// - Force two drives level two if enabled
// - Force one drives level one if enabled
// - Level two on pin two, pin one in modes
// - Edge select one picks pin one polarity
// - Level one to pin one on first match
// - Pin one enable only connects the pin
// - Pin two enable only connects the pin
// - One-pulse: pin one edge fires pulse
// - Pulse-width second match reloads FFFC
// - Status read then low read clears flag
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "tmctl_consts.vh"

module tmctl_timer (
    sys_clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    cpu_mask,
    halt_mode,
    capture_in_pin_one,
    capture_in_pin_two,
    compare_out_pin_one,
    compare_out_pin_one_oe,
    compare_out_pin_two,
    compare_out_pin_two_oe,
    timer_irq,
    wake_from_wait
);
    input  wire       sys_clk;                // Timer clock
    input  wire       rst_n;                  // Async reset, active low
    input  wire [3:0] reg_addr;               // Register byte address
    input  wire [7:0] reg_wdata;              // Write data
    input  wire       reg_wr;                 // Write strobe
    input  wire       reg_rd;                 // Read strobe
    output reg  [7:0] reg_rdata;              // Read data, cycle after strobe
    input  wire       cpu_mask;               // Core interrupt mask, 1 masks
    input  wire       halt_mode;              // Core in halt
    input  wire       capture_in_pin_one;     // Capture pin one
    input  wire       capture_in_pin_two;     // Capture pin two
    output wire       compare_out_pin_one;    // Compare pin one level
    output wire       compare_out_pin_one_oe; // Pin one owned by timer
    output wire       compare_out_pin_two;    // Compare pin two level
    output wire       compare_out_pin_two_oe; // Pin two owned by timer
    output wire       timer_irq;              // Shared timer interrupt
    output wire       wake_from_wait;         // Wait-mode wake request

    // ****************************************************
    // Storage
    // ****************************************************
    reg  [7:0]  control_one_ff;   // Control one
    reg  [7:0]  control_two_ff;   // Control two
    reg  [15:0] counter_ff;       // Free-running counter
    reg  [15:0] cmp1_ff;          // Compare value one
    reg  [15:0] cmp2_ff;          // Compare value two
    reg  [15:0] cap1_ff;          // Capture value one
    reg  [15:0] cap2_ff;          // Capture value two
    reg         inh1_ff;          // Compare one suspended
    reg         inh2_ff;          // Compare two suspended
    reg  [4:0]  flags_ff;         // cap1,cmp1,ovf,cap2,cmp2
    reg  [4:0]  seen_ff;          // Flags seen set in last status read
    reg         arm1_ff;          // Capture one armed in halt
    reg         arm2_ff;          // Capture two armed in halt
    reg         halt_d_ff;        // Halt delayed, for exit detection
    reg         out1_ff;          // Compare pin one level
    reg         out2_ff;          // Compare pin two level
    reg  [4:0]  nxt_flags;        // Flag next value
    reg  [4:0]  set_ev;           // Hardware set events
    reg  [4:0]  clr_ev;           // Software clear events

    wire        edge1;            // Selected edge on pin one
    wire        edge2;            // Selected edge on pin two
    wire        pwm_mode;         // Pulse-width active
    wire        opm_mode;         // One-pulse active
    wire        halt_exit;        // Halt released this cycle
    wire        match1;           // Counter equals compare one
    wire        match2;           // Counter equals compare two
    wire        ovf;              // Counter rolls over
    wire        cap1_hit;         // Capture one fires
    wire        cap2_hit;         // Capture two fires
    wire        rd_stat;          // Status read
    wire        acc_cap1;         // Capture one low accessed
    wire        acc_cap2;         // Capture two low accessed
    wire        acc_cmp1;         // Compare one low accessed
    wire        acc_cmp2;         // Compare two low accessed
    wire        acc_cnt;          // Counter low accessed

    // ****************************************************
    // Pin edge detectors
    // ****************************************************
    tmctl_edge u_edge1 (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   (capture_in_pin_one),
        .rise_sel (control_one_ff[`TMCTL_C1_EDGE1]),
        .edge_hit (edge1)
    );

    tmctl_edge u_edge2 (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   (capture_in_pin_two),
        .rise_sel (control_two_ff[`TMCTL_C2_EDGE2]),
        .edge_hit (edge2)
    );

    // ****************************************************
    // Mode decode
    // ****************************************************
    assign pwm_mode  = control_two_ff[`TMCTL_C2_PWM];
    // Pulse-width takes priority so both set means pulse-width only
    assign opm_mode  = control_two_ff[`TMCTL_C2_ONE_PULSE] & ~pwm_mode;
    assign halt_exit = halt_d_ff & ~halt_mode;

    // Compare waits for its low byte
    assign match1 = ~halt_mode & ~inh1_ff & (counter_ff == cmp1_ff);
    assign match2 = ~halt_mode & ~inh2_ff & (counter_ff == cmp2_ff);
    assign ovf    = ~halt_mode & (counter_ff == 16'hFFFF);

    // Pin one cut off in pulse-width; halt edges wait
    assign cap1_hit = ~pwm_mode & ((edge1 & ~halt_mode) | (halt_exit & arm1_ff));
    assign cap2_hit = (edge2 & ~halt_mode) | (halt_exit & arm2_ff);

    // Register access decode
    assign rd_stat  = reg_rd & (reg_addr == `TMCTL_ADR_STAT);
    assign acc_cap1 = (reg_rd | reg_wr) & (reg_addr == `TMCTL_ADR_CAP1_LO);
    assign acc_cap2 = (reg_rd | reg_wr) & (reg_addr == `TMCTL_ADR_CAP2_LO);
    assign acc_cmp1 = (reg_rd | reg_wr) & (reg_addr == `TMCTL_ADR_CMP1_LO);
    assign acc_cmp2 = (reg_rd | reg_wr) & (reg_addr == `TMCTL_ADR_CMP2_LO);
    assign acc_cnt  = (reg_rd | reg_wr) & (reg_addr == `TMCTL_ADR_CNT_LO);

    // ****************************************************
    // Flag set and clear; a set in the clearing cycle wins
    // ****************************************************
    always @* begin
        set_ev = 5'h00;
        // Pulse-width second match sets capture one
        set_ev[4] = cap1_hit | (pwm_mode & match2) | (opm_mode & edge1 & ~halt_mode);
        // No compare flags in pulse-width
        set_ev[3] = match1 & ~pwm_mode & ~opm_mode;
        set_ev[2] = ovf;
        set_ev[1] = cap2_hit;
        set_ev[0] = match2 & ~pwm_mode;
        clr_ev = {acc_cap1 & seen_ff[4], acc_cmp1 & seen_ff[3], acc_cnt & seen_ff[2],
                  acc_cap2 & seen_ff[1], acc_cmp2 & seen_ff[0]};
        nxt_flags = (flags_ff & ~clr_ev) | set_ev;
    end

    // ****************************************************
    // Counter, captures and flags
    // ****************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_ff <= `TMCTL_CNT_RST;
            cap1_ff    <= 16'h0000;
            cap2_ff    <= 16'h0000;
            flags_ff   <= 5'h00;
            seen_ff    <= 5'h00;
            arm1_ff    <= 1'b0;
            arm2_ff    <= 1'b0;
            halt_d_ff  <= 1'b0;
        end else begin
            halt_d_ff <= halt_mode;
            flags_ff  <= nxt_flags;
            // Status read arms the clears
            if (rd_stat) begin
                seen_ff <= flags_ff;
            end else if (|clr_ev) begin
                seen_ff <= seen_ff & ~clr_ev;
            end
            // Halt edges only arm
            if (halt_mode) begin
                if (edge1 & ~pwm_mode) arm1_ff <= 1'b1;
                if (edge2) arm2_ff <= 1'b1;
            end else begin
                arm1_ff <= 1'b0;
                arm2_ff <= 1'b0;
            end
            // Counter value at exit is what gets captured
            if (cap1_hit & ~opm_mode) cap1_ff <= counter_ff;
            if (cap2_hit) cap2_ff <= counter_ff;
            // Counter: frozen in halt, keeps running in wait
            if (halt_mode) begin
                counter_ff <= counter_ff;
            end else if (reg_wr & (reg_addr == `TMCTL_ADR_CNT_LO)) begin
                counter_ff <= `TMCTL_CNT_RST;
            end else if (pwm_mode & match2) begin
                counter_ff <= `TMCTL_CNT_RELOAD;
            end else if (opm_mode & edge1) begin
                counter_ff <= `TMCTL_CNT_RELOAD;
                cap1_ff    <= `TMCTL_CAP_OPM_VAL;
            end else begin
                counter_ff <= counter_ff + 16'h0001;
            end
        end
    end

    // ****************************************************
    // Software registers
    // ****************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_one_ff <= `TMCTL_CTL1_RST;
            control_two_ff <= `TMCTL_CTL2_RST;
            cmp1_ff        <= `TMCTL_CMP_RST;
            cmp2_ff        <= `TMCTL_CMP_RST;
            inh1_ff        <= 1'b0;
            inh2_ff        <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `TMCTL_ADR_CTL1: begin
                    control_one_ff <= reg_wdata;
                end
                `TMCTL_ADR_CTL2: begin
                    control_two_ff <= reg_wdata;
                end
                `TMCTL_ADR_CMP1_HI: begin
                    cmp1_ff[15:8] <= reg_wdata;
                    inh1_ff       <= 1'b1;
                end
                `TMCTL_ADR_CMP1_LO: begin
                    cmp1_ff[7:0] <= reg_wdata;
                    inh1_ff      <= 1'b0;
                end
                `TMCTL_ADR_CMP2_HI: begin
                    cmp2_ff[15:8] <= reg_wdata;
                    inh2_ff       <= 1'b1;
                end
                `TMCTL_ADR_CMP2_LO: begin
                    cmp2_ff[7:0] <= reg_wdata;
                    inh2_ff      <= 1'b0;
                end
                default: begin
                    // Read-only or unmapped: write ignored
                    inh1_ff <= inh1_ff;
                end
            endcase
        end
    end

    // ****************************************************
    // Compare outputs
    // ****************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out1_ff <= 1'b0;
            out2_ff <= 1'b0;
        end else begin
            // Channel one: special modes use both levels
            if (pwm_mode) begin
                if (match2) out1_ff <= control_one_ff[`TMCTL_C1_LVL2];
                else if (match1) out1_ff <= control_one_ff[`TMCTL_C1_LVL1];
            end else if (opm_mode) begin
                if (edge1 & ~halt_mode) out1_ff <= control_one_ff[`TMCTL_C1_LVL2];
                else if (match1) out1_ff <= control_one_ff[`TMCTL_C1_LVL1];
            end else if (control_one_ff[`TMCTL_C1_FORCE1]) begin
                out1_ff <= control_one_ff[`TMCTL_C1_LVL1];
            end else if (match1) begin
                out1_ff <= control_one_ff[`TMCTL_C1_LVL1];
            end
            // Channel two: plain mode only
            if (~pwm_mode & ~opm_mode) begin
                if (control_one_ff[`TMCTL_C1_FORCE2]) out2_ff <= control_one_ff[`TMCTL_C1_LVL2];
                else if (match2) out2_ff <= control_one_ff[`TMCTL_C1_LVL2];
            end
        end
    end

    // Enables only hand the pin over
    assign compare_out_pin_one    = out1_ff;
    assign compare_out_pin_one_oe = control_two_ff[`TMCTL_C2_PIN1_EN];
    assign compare_out_pin_two    = out2_ff;
    assign compare_out_pin_two_oe = control_two_ff[`TMCTL_C2_PIN2_EN];

    // ****************************************************
    // Interrupt: one shared vector, per-group enables
    // ****************************************************
    wire irq_raw;  // Gated flag OR before core mask
    assign irq_raw = (control_one_ff[`TMCTL_C1_CAP_IE] & (flags_ff[4] | flags_ff[1]))
                   | (control_one_ff[`TMCTL_C1_CMP_IE] & (flags_ff[3] | flags_ff[0]))
                   | (control_one_ff[`TMCTL_C1_OVF_IE] & flags_ff[2]);
    assign timer_irq = irq_raw & ~cpu_mask;
    // Timer events end wait but never halt
    assign wake_from_wait = timer_irq & ~halt_mode;

    // ****************************************************
    // Read data, one cycle after the strobe
    // ****************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TMCTL_ADR_CTL1:    reg_rdata <= control_one_ff;
                `TMCTL_ADR_CTL2:    reg_rdata <= control_two_ff;
                `TMCTL_ADR_STAT:    reg_rdata <= {flags_ff, 3'b000};
                `TMCTL_ADR_CAP1_HI: reg_rdata <= cap1_ff[15:8];
                `TMCTL_ADR_CAP1_LO: reg_rdata <= cap1_ff[7:0];
                `TMCTL_ADR_CMP1_HI: reg_rdata <= cmp1_ff[15:8];
                `TMCTL_ADR_CMP1_LO: reg_rdata <= cmp1_ff[7:0];
                `TMCTL_ADR_CAP2_HI: reg_rdata <= cap2_ff[15:8];
                `TMCTL_ADR_CAP2_LO: reg_rdata <= cap2_ff[7:0];
                `TMCTL_ADR_CMP2_HI: reg_rdata <= cmp2_ff[15:8];
                `TMCTL_ADR_CMP2_LO: reg_rdata <= cmp2_ff[7:0];
                `TMCTL_ADR_CNT_HI:  reg_rdata <= counter_ff[15:8];
                `TMCTL_ADR_CNT_LO:  reg_rdata <= counter_ff[7:0];
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// [tmctl_timer_sva.sv]
// Checker for the timer control block.
// Assumes it is bound to tmctl_timer and sees only its ports.
`timescale 1ns/1ns
module tmctl_timer_sva (
    input wire       sys_clk,
    input wire       rst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       cpu_mask,
    input wire       halt_mode,
    input wire       compare_out_pin_one,
    input wire       compare_out_pin_one_oe,
    input wire       compare_out_pin_two,
    input wire       compare_out_pin_two_oe,
    input wire       timer_irq,
    input wire       wake_from_wait
);
    // ****************************************
    // Shadow copies of both control registers
    // ****************************************
    reg  [7:0] ctl1_ff; // Control one as last written
    reg  [7:0] ctl2_ff; // Control two as last written
    wire       plain;   // No pulse mode
    assign plain = !ctl2_ff[5] && !ctl2_ff[4];
    // Track writes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl1_ff <= 8'h00;
            ctl2_ff <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 4'h2) ctl1_ff <= reg_wdata;
            if (reg_addr == 4'h1) ctl2_ff <= reg_wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Properties
    // ****************************************
    AST_IRQ_MASK: assert property (timer_irq |-> !cpu_mask)
        else $error("interrupt raised while masked");
    AST_IRQ_GATE: assert property (timer_irq |-> (|ctl1_ff[7:5]))
        else $error("interrupt raised with all enables clear");
    AST_WAKE_HALT: assert property (halt_mode |-> !wake_from_wait)
        else $error("timer event ends halt");
    AST_WAKE_RUN: assert property (!halt_mode |-> wake_from_wait == timer_irq)
        else $error("wake request differs from interrupt");
    AST_OE_ONE: assert property (reg_wr && reg_addr == 4'h1 |=>
        compare_out_pin_one_oe == $past(reg_wdata[7]))
        else $error("pin one ownership wrong");
    AST_OE_TWO: assert property (reg_wr && reg_addr == 4'h1 |=>
        compare_out_pin_two_oe == $past(reg_wdata[6]))
        else $error("pin two ownership wrong");
    AST_FORCE_ONE: assert property (ctl1_ff[3] && ctl2_ff[7] && plain |->
        ##[0:2] compare_out_pin_one == ctl1_ff[0])
        else $error("forced level one missing");
    AST_FORCE_TWO: assert property (ctl1_ff[4] && ctl2_ff[6] && plain |->
        ##[0:2] compare_out_pin_two == ctl1_ff[2])
        else $error("forced level two missing");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_CTL_READ: assert property (reg_rd && reg_addr == 4'h2 |=>
        reg_rdata == $past(ctl1_ff))
        else $error("control one reads back wrong");
endmodule
bind tmctl_timer tmctl_timer_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_mask(cpu_mask), .halt_mode(halt_mode),
    .compare_out_pin_one(compare_out_pin_one), .compare_out_pin_one_oe(compare_out_pin_one_oe),
    .compare_out_pin_two(compare_out_pin_two), .compare_out_pin_two_oe(compare_out_pin_two_oe),
    .timer_irq(timer_irq), .wake_from_wait(wake_from_wait));
